/* File: pic_regs.svh */
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH
`define PIC_ADDR_WR 8'h34
`define PIC_ADDR_RD 8'h35
`define PIC_SUB_INC 5'h00
`define PIC_SUB_FIX 5'h1e
`define PIC_REG_ALPHA_GAIN 3'h0
`define PIC_REG_ALPHA_SW 3'h1
`define PIC_REG_NORM_GAIN 3'h2
`define PIC_REG_CLAMP_SUM 3'h3
`define PIC_REG_DROPOUT 3'h4
`define PIC_REG_BETA 3'h5
`define PIC_REG_PUSH_PULL 3'h6
`define PIC_REG_MODE 3'h7
`define PIC_RST_ZERO 8'h00
`define PIC_RST_BETA 8'h1f
`define PIC_RST_PUSH_PULL 8'h60
`define PIC_PORR_BIT 7
`define PIC_STATUS_BIT 7
`endif

/* File: pic_pkg.sv */
package pic_pkg;
  typedef enum logic [3:0] {
    PIC_IDLE = 4'b0000,
    PIC_ADDR = 4'b0001,
    PIC_ADDR_ACK = 4'b0010,
    PIC_SUB = 4'b0011,
    PIC_SUB_ACK = 4'b0100,
    PIC_DATA = 4'b0101,
    PIC_DATA_ACK = 4'b0110,
    PIC_RD = 4'b0111,
    PIC_RD_ACK = 4'b1000
  } pic_state_type;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } pic_bus_ev_type;

  typedef struct packed {
    logic scl_meta;
    logic scl_s;
    logic scl_p;
    logic sda_meta;
    logic sda_s;
    logic sda_p;
  } pic_sync_st_type;

  typedef struct packed {
    pic_state_type fsm;
    logic [2:0] bit_cnt;
    logic byte_done;
    logic [7:0] shift;
    logic sda_low;
    logic rd_mode;
    logic [2:0] ptr;
    logic inc_en;
    logic [7:0][7:0] regs;
    logic [7:0] rd_byte;
  } pic_core_st_type;

  typedef struct packed {
    logic [2:0] alpha_in_gain;
    logic [4:0] alpha_dac;
    logic [1:0] cdr_alpha_gain;
    logic cdr_alpha_power;
    logic peak_test;
    logic rw_mode2;
    logic rw_alpha;
    logic [1:0] power_error_output_gain;
    logic [1:0] track_loss_gain;
    logic radial_self_test;
    logic [4:0] norm_dac;
    logic dac_test;
    logic clamp_low;
    logic clamp_high;
    logic [4:0] sum_ref_dac;
    logic [7:0] dropout_dac;
    logic input_res_opt;
    logic [1:0] averaged_aperture_signal_bw;
    logic [4:0] beta_dac;
    logic pp_fast_en;
    logic pp_slow_en;
    logic [4:0] pp_dac;
    logic [1:0] adjust_sel;
    logic [1:0] wobble_bw;
    logic disc_rw;
    logic uref_high;
  } pic_ctrl_type;
endpackage : pic_pkg

/* File: pic_pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module pic_pin_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output pic_pkg::pic_bus_ev_type o_ev
);
  import pic_pkg::*;

  pic_sync_st_type st_q;
  pic_sync_st_type st_d;

  always_comb begin
    st_d = st_q;
    st_d.scl_meta = i_scl;
    st_d.scl_s = st_q.scl_meta;
    st_d.scl_p = st_q.scl_s;
    st_d.sda_meta = i_sda;
    st_d.sda_s = st_q.sda_meta;
    st_d.sda_p = st_q.sda_s;
  end

  // Idle bus lines are high, so reset to high to avoid a false start
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_ev.scl = st_q.scl_s;
  assign o_ev.sda = st_q.sda_s;
  assign o_ev.scl_rise = st_q.scl_s & ~st_q.scl_p;
  assign o_ev.scl_fall = ~st_q.scl_s & st_q.scl_p;
  assign o_ev.start = st_q.scl_s & st_q.scl_p & st_q.sda_p & ~st_q.sda_s;
  assign o_ev.stop = st_q.scl_s & st_q.scl_p & ~st_q.sda_p & st_q.sda_s;
endmodule : pic_pin_sync
`default_nettype wire

/* File: pic_ctrl_bank.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pic_regs.svh"
module pic_ctrl_bank (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE_N,
  output logic O_POR_FLAG,
  output pic_pkg::pic_ctrl_type O_CTRL
);
  import pic_pkg::*;

  localparam logic [7:0][7:0] RST_VALS = {
    `PIC_RST_ZERO,
    `PIC_RST_PUSH_PULL,
    `PIC_RST_BETA,
    `PIC_RST_ZERO,
    `PIC_RST_ZERO,
    `PIC_RST_ZERO,
    `PIC_RST_ZERO,
    `PIC_RST_ZERO
  };

  localparam pic_core_st_type ST_RESET = '{
    fsm: PIC_IDLE,
    bit_cnt: 3'h0,
    byte_done: 1'b0,
    shift: 8'h00,
    sda_low: 1'b0,
    rd_mode: 1'b0,
    ptr: 3'h0,
    inc_en: 1'b0,
    regs: RST_VALS,
    rd_byte: 8'h00
  };

  pic_bus_ev_type ev;
  pic_core_st_type st_q;
  pic_core_st_type st_d;
  logic [7:0] reg_match;
  logic por_flag;
  logic [7:0] status_byte;
  logic [7:0] r0;
  logic [7:0] r1;
  logic [7:0] r2;
  logic [7:0] r3;
  logic [7:0] r4;
  logic [7:0] r5;
  logic [7:0] r6;
  logic [7:0] r7;

  pic_pin_sync u_sync (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_scl(I_SCL),
    .i_sda(I_SDA),
    .o_ev(ev)
  );

  // Per-register compare against the reset image
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_match
      assign reg_match[g] = (st_q.regs[g] == RST_VALS[g]);
    end
  endgenerate

  // Set bit 7 of register 07H lifts the bank out of the reset image
  always_comb begin
    por_flag = &reg_match;
    if (st_q.regs[`PIC_REG_MODE][`PIC_PORR_BIT]) begin
      por_flag = 1'b0;
    end
    status_byte = 8'h00;
    status_byte[`PIC_STATUS_BIT] = por_flag;
  end

  always_comb begin
    st_d = st_q;
    if (ev.stop) begin
      st_d.fsm = PIC_IDLE;
      st_d.sda_low = 1'b0;
      st_d.byte_done = 1'b0;
    end else if (ev.start) begin
      st_d.fsm = PIC_ADDR;
      st_d.bit_cnt = 3'h0;
      st_d.byte_done = 1'b0;
      st_d.sda_low = 1'b0;
    end else begin
      case (st_q.fsm)
        PIC_IDLE: begin
          st_d.sda_low = 1'b0;
        end
        PIC_ADDR, PIC_SUB, PIC_DATA: begin
          if (ev.scl_rise) begin
            st_d.shift = {st_q.shift[6:0], ev.sda};
            st_d.bit_cnt = st_q.bit_cnt + 3'h1;
            if (st_q.bit_cnt == 3'h7) begin
              st_d.byte_done = 1'b1;
            end
          end
          if (ev.scl_fall && st_q.byte_done) begin
            st_d.byte_done = 1'b0;
            st_d.fsm = PIC_IDLE;
            if (st_q.fsm == PIC_ADDR) begin
              if (st_q.shift == `PIC_ADDR_WR) begin
                st_d.rd_mode = 1'b0;
                st_d.sda_low = 1'b1;
                st_d.fsm = PIC_ADDR_ACK;
              end else if (st_q.shift == `PIC_ADDR_RD) begin
                st_d.rd_mode = 1'b1;
                st_d.sda_low = 1'b1;
                st_d.fsm = PIC_ADDR_ACK;
              end
            end else if (st_q.fsm == PIC_SUB) begin
              if (st_q.shift[7:3] == `PIC_SUB_INC) begin
                st_d.ptr = st_q.shift[2:0];
                st_d.inc_en = 1'b1;
                st_d.sda_low = 1'b1;
                st_d.fsm = PIC_SUB_ACK;
              end else if (st_q.shift[7:3] == `PIC_SUB_FIX) begin
                st_d.ptr = st_q.shift[2:0];
                st_d.inc_en = 1'b0;
                st_d.sda_low = 1'b1;
                st_d.fsm = PIC_SUB_ACK;
              end
            end else begin
              st_d.regs[st_q.ptr] = st_q.shift;
              if (st_q.inc_en) begin
                // Three-bit pointer rolls from 07H to 00H by itself
                st_d.ptr = st_q.ptr + 3'h1;
              end
              st_d.sda_low = 1'b1;
              st_d.fsm = PIC_DATA_ACK;
            end
          end
        end
        PIC_ADDR_ACK: begin
          if (ev.scl_fall) begin
            st_d.sda_low = 1'b0;
            st_d.bit_cnt = 3'h0;
            if (st_q.rd_mode) begin
              // Status is captured as the first bit goes out
              st_d.rd_byte = status_byte;
              st_d.sda_low = ~status_byte[7];
              st_d.fsm = PIC_RD;
            end else begin
              st_d.fsm = PIC_SUB;
            end
          end
        end
        PIC_SUB_ACK, PIC_DATA_ACK: begin
          if (ev.scl_fall) begin
            st_d.sda_low = 1'b0;
            st_d.bit_cnt = 3'h0;
            st_d.fsm = PIC_DATA;
          end
        end
        PIC_RD: begin
          if (ev.scl_rise) begin
            st_d.bit_cnt = st_q.bit_cnt + 3'h1;
          end
          if (ev.scl_fall) begin
            if (st_q.bit_cnt == 3'h0) begin
              st_d.sda_low = 1'b0;
              st_d.fsm = PIC_RD_ACK;
            end else begin
              st_d.rd_byte = {st_q.rd_byte[6:0], 1'b0};
              st_d.sda_low = ~st_q.rd_byte[6];
            end
          end
        end
        PIC_RD_ACK: begin
          if (ev.scl_rise) begin
            if (ev.sda) begin
              st_d.fsm = PIC_IDLE;
            end else begin
              // Master asked for more: repeat the status byte
              st_d.fsm = PIC_ADDR_ACK;
            end
          end
        end
        default: begin
          st_d.fsm = PIC_IDLE;
          st_d.sda_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign O_SDA = 1'b0;
  assign O_SDA_OE_N = ~st_q.sda_low;
  assign O_POR_FLAG = por_flag;

  assign r0 = st_q.regs[`PIC_REG_ALPHA_GAIN];
  assign r1 = st_q.regs[`PIC_REG_ALPHA_SW];
  assign r2 = st_q.regs[`PIC_REG_NORM_GAIN];
  assign r3 = st_q.regs[`PIC_REG_CLAMP_SUM];
  assign r4 = st_q.regs[`PIC_REG_DROPOUT];
  assign r5 = st_q.regs[`PIC_REG_BETA];
  assign r6 = st_q.regs[`PIC_REG_PUSH_PULL];
  assign r7 = st_q.regs[`PIC_REG_MODE];

  // Register 00H
  assign O_CTRL.alpha_in_gain = r0[7:5];
  assign O_CTRL.alpha_dac = r0[4:0];

  // Register 01H, bit 7 is free
  assign O_CTRL.cdr_alpha_gain = {r1[6], r1[4]};
  assign O_CTRL.cdr_alpha_power = r1[4];
  assign O_CTRL.peak_test = r1[5];
  assign O_CTRL.rw_mode2 = r1[3];
  assign O_CTRL.rw_alpha = r1[2];
  assign O_CTRL.power_error_output_gain = r1[1:0];

  // Register 02H
  assign O_CTRL.track_loss_gain = r2[7:6];
  assign O_CTRL.radial_self_test = r2[5];
  assign O_CTRL.norm_dac = r2[4:0];

  // Register 03H, bit 5 alone picks the low clamp
  assign O_CTRL.dac_test = r3[7];
  assign O_CTRL.clamp_low = r3[5];
  assign O_CTRL.clamp_high = r3[6] & ~r3[5];
  assign O_CTRL.sum_ref_dac = r3[4:0];

  // Register 04H
  assign O_CTRL.dropout_dac = r4;

  // Register 05H
  assign O_CTRL.input_res_opt = r5[7];
  assign O_CTRL.averaged_aperture_signal_bw = r5[6:5];
  assign O_CTRL.beta_dac = r5[4:0];

  // Register 06H, bit 7 is free
  assign O_CTRL.pp_fast_en = r6[6];
  assign O_CTRL.pp_slow_en = r6[5];
  assign O_CTRL.pp_dac = r6[4:0];

  // Register 07H, bit 6 drives nothing; bit 7 only clears the reset flag
  assign O_CTRL.adjust_sel = r7[1:0];
  assign O_CTRL.wobble_bw = r7[3:2];
  assign O_CTRL.disc_rw = r7[4];
  assign O_CTRL.uref_high = r7[5];
endmodule : pic_ctrl_bank
`default_nettype wire

/* File: pic_ctrl_bank_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module pic_ctrl_bank_properties (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic O_SDA,
  input wire logic O_SDA_OE_N,
  input wire logic O_POR_FLAG,
  input wire pic_pkg::pic_ctrl_type O_CTRL
);
  import pic_pkg::*;
  pic_ctrl_type img;
  always_comb begin
    img = '0;
    img.beta_dac = 5'h1f;
    img.pp_fast_en = 1'b1;
    img.pp_slow_en = 1'b1;
  end
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  // An acknowledge or read bit holds the line low for at least eight system clocks
  sequence ack_low;
    !O_SDA_OE_N [*8];
  endsequence
  reset_image_a: assert property ($fell(I_RST) |-> O_POR_FLAG && O_CTRL == img)
    else $error("reset image wrong");
  flag_image_a: assert property (O_POR_FLAG |-> O_CTRL == img)
    else $error("flag set off image");
  flag_clear_a: assert property (O_CTRL != img |-> !O_POR_FLAG)
    else $error("flag not cleared");
  write_ack_a: assert property (!$stable(O_CTRL) |-> ##[0:1] !O_SDA_OE_N)
    else $error("write without ack");
  ack_hold_a: assert property ($fell(O_SDA_OE_N) |-> ack_low)
    else $error("ack too short");
  sda_change_a: assert property ($fell(O_SDA_OE_N) || $rose(O_SDA_OE_N) |-> !I_SCL && !$past(I_SCL))
    else $error("data moved with clock high");
  ctrl_quiet_a: assert property (!$stable(O_CTRL) |-> !I_SCL && !$past(I_SCL))
    else $error("control moved with clock high");
  clamp_decode_a: assert property (O_CTRL.clamp_high |-> !O_CTRL.clamp_low)
    else $error("both clamps on");
  alpha_power_a: assert property (O_CTRL.cdr_alpha_power == O_CTRL.cdr_alpha_gain[0])
    else $error("alpha power mismatch");
endmodule : pic_ctrl_bank_properties
bind pic_ctrl_bank pic_ctrl_bank_properties pic_ctrl_bank_properties_inst (.I_SYS_CLK(I_SYS_CLK),
  .I_RST(I_RST), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA(O_SDA), .O_SDA_OE_N(O_SDA_OE_N),
  .O_POR_FLAG(O_POR_FLAG), .O_CTRL(O_CTRL));
`default_nettype wire

/* File: pic_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pic_host_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask : tick
  task automatic bus_start();
    o_sda = 1'b1;
    tick(4);
    o_scl = 1'b1;
    tick(8);
    o_sda = 1'b0;
    tick(8);
    o_scl = 1'b0;
    tick(4);
  endtask : bus_start
  task automatic bus_stop();
    o_sda = 1'b0;
    tick(4);
    o_scl = 1'b1;
    tick(8);
    o_sda = 1'b1;
    tick(8);
  endtask : bus_stop
  // Data moves only with the clock low; sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    o_sda = b;
    tick(4);
    o_scl = 1'b1;
    tick(8);
    r = i_sda;
    o_scl = 1'b0;
    tick(4);
  endtask : bit_io
  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_out
  task automatic byte_in(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(~mack, r);
  endtask : byte_in
endmodule : pic_host_model
`default_nettype wire

/* File: pic_ctrl_bank_test.sv */
`timescale 1ns/1ns
`default_nettype none
module pic_ctrl_bank_test;
  import pic_pkg::*;
  localparam logic [63:0] RST_REGS = 64'h00601f0000000000;
  logic sys_clk;
  logic rst;
  logic scl;
  logic host_sda;
  logic sda_line;
  logic sda_o;
  logic sda_oe_n;
  logic por_flag;
  pic_ctrl_type ctrl;
  logic [7:0][7:0] exp_q;
  logic [15:0] free_bits [4] = '{16'hf180, 16'hf6e0, 16'hf740, 16'hf780};
  int fails;
  int checks;
  // Open-drain data line with pull-up
  assign sda_line = host_sda & (sda_oe_n | sda_o);
  pic_ctrl_bank pic_ctrl_bank_inst (.I_SYS_CLK(sys_clk), .I_RST(rst), .I_SCL(scl),
    .I_SDA(sda_line), .O_SDA(sda_o), .O_SDA_OE_N(sda_oe_n), .O_POR_FLAG(por_flag),
    .O_CTRL(ctrl));
  pic_host_model pic_host_model_inst (.i_clk(sys_clk), .i_sda(sda_line), .o_scl(scl),
    .o_sda(host_sda));
  function automatic pic_ctrl_type ctrl_of(input logic [7:0][7:0] r);
    return {r[0], r[1][6], r[1][4], r[1][4], r[1][5], r[1][3:0], r[2], r[3][7], r[3][5],
      r[3][6] & ~r[3][5], r[3][4:0], r[4], r[5], r[6][6:0], r[7][1:0], r[7][3:2], r[7][4],
      r[7][5]};
  endfunction : ctrl_of
  task automatic check(input string what, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic check_state();
    check("controls", 64'(ctrl_of(exp_q)), 64'(ctrl));
    check("flag", 64'(exp_q == RST_REGS), 64'(por_flag));
  endtask : check_state
  task automatic wr(input logic [7:0] addr, input logic [7:0] sub, input int n,
      input logic [63:0] d);
    logic ack;
    logic good;
    logic [2:0] ptr;
    ptr = sub[2:0];
    good = sub[7:3] == 5'h00 || sub[7:3] == 5'h1e;
    pic_host_model_inst.bus_start();
    pic_host_model_inst.byte_out(addr, ack);
    check("address ack", 64'(addr == 8'h34), 64'(ack));
    if (ack === 1'b1) begin
      pic_host_model_inst.byte_out(sub, ack);
      check("sub ack", 64'(good), 64'(ack));
      for (int i = 0; i < n; i++) begin
        pic_host_model_inst.byte_out(d[8*i +: 8], ack);
        check("data ack", 64'(good), 64'(ack));
        if (good) begin
          exp_q[ptr] = d[8*i +: 8];
          ptr = ptr + 3'(sub[7:3] == 5'h00);
        end
      end
    end
    pic_host_model_inst.bus_stop();
    check_state();
  endtask : wr
  task automatic rd();
    logic ack;
    logic [7:0] b;
    pic_host_model_inst.bus_start();
    pic_host_model_inst.byte_out(8'h35, ack);
    check("read ack", 64'h1, 64'(ack));
    pic_host_model_inst.byte_in(1'b0, b);
    pic_host_model_inst.bus_stop();
    check("status", 64'(exp_q == RST_REGS), 64'(b[7]));
  endtask : rd
  task automatic done(input string name);
    $display("test %s done, mismatches %0d", name, fails);
  endtask : done
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    stop_test();
  end
  initial begin
    fails = 0;
    checks = 0;
    rst = 1'b1;
    exp_q = RST_REGS;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    check_state();
    rd();
    done("reset");
    wr(8'h34, 8'h07, 3, 64'h5ac381);
    wr(8'h34, 8'h00, 8, 64'h3c96e14bd2780fa5);
    rd();
    done("increment");
    for (int i = 0; i < 8; i++) begin
      wr(8'h34, 8'hf3, 2, {48'h0, 3'(i), 5'h0a, 8'h00});
    end
    done("fixed");
    wr(8'h34, 8'h00, 8, RST_REGS);
    rd();
    foreach (free_bits[i]) begin
      wr(8'h34, free_bits[i][15:8], 1, {56'h0, free_bits[i][7:0]});
      rd();
      wr(8'h34, free_bits[i][15:8], 1, {56'h0, RST_REGS[8*free_bits[i][10:8] +: 8]});
    end
    done("status");
    wr(8'h36, 8'h00, 1, 64'hff);
    wr(8'h34, 8'h08, 1, 64'hff);
    wr(8'h34, 8'he1, 2, 64'hffff);
    rd();
    done("refused");
    stop_test();
  end
endmodule : pic_ctrl_bank_test
`default_nettype wire
